//--- sfb_pkg.sv
// package of constants and types for the stacked flash bus pin front end
`default_nettype none
package sfb_pkg;
   localparam int sfb_addr_w_64m = 22;
   localparam int sfb_addr_w_128m = 23;
   localparam int sfb_addr_w_256m = 24;
   localparam int sfb_addr_w_512m = 25;
   localparam int sfb_data_w = 16;
   localparam int sfb_wait_pol_bit = 10;
   localparam int sfb_cfg_w = 16;
   localparam logic [15:0] sfb_cfg_reset = 16'hffcf;
   localparam logic [3:0] sfb_latency_reset = 4'h3;
   // command codes on the low byte
   localparam logic [7:0] sfb_cmd_read_array = 8'hff;
   localparam logic [7:0] sfb_cmd_read_status = 8'h70;
   localparam logic [7:0] sfb_cmd_cfg_setup = 8'h60;
   localparam logic [7:0] sfb_cmd_cfg_confirm = 8'h03;
   localparam logic [7:0] sfb_cmd_unlock = 8'hd0;
   localparam logic [7:0] sfb_cmd_lockdown = 8'h2f;
   localparam logic [7:0] sfb_cmd_program = 8'h40;
   localparam int sfb_sync_mode_bit = 15;
   localparam int sfb_lat_lsb = 11;
   localparam int sfb_lat_w = 4;
   typedef enum logic [1:0] {
      sfb_st_array = 2'b00,
      sfb_st_status = 2'b01,
      sfb_st_cfg = 2'b10,
      sfb_st_prog = 2'b11
   } sfb_state_t;
endpackage : sfb_pkg
`default_nettype wire

//--- sfb_sync3.sv
// three-stage pin synchroniser with agreement on the last two stages
`default_nettype none
module sfb_sync3
   import sfb_pkg::*;
#(
   parameter int width = 1,
   parameter logic [width-1:0] init = '0
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [width-1:0] pin,
   output logic [width-1:0] q
);
   typedef struct packed {
      logic [width-1:0] s1;
      logic [width-1:0] s2;
      logic [width-1:0] s3;
      logic [width-1:0] q;
   } sfb_sync_t;
   sfb_sync_t r;
   sfb_sync_t next_r;

   initial begin
      if (width < 1) $error("sfb_sync3 width must be positive");
   end

   // per bit, the output moves only when stages two and three agree
   always_comb begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < width; i++) begin
         if (r.s2[i] == r.s3[i]) next_r.q[i] = r.s3[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         r <= '{s1: init, s2: init, s3: init, q: init};
      end else begin
         r <= next_r;
      end
   end
   assign q = r.q;
endmodule : sfb_sync3
`default_nettype wire

//--- sfb_flash_bus.sv
// pin-level bus front end of a stacked nor flash die pair
`default_nettype none
module sfb_flash_bus
   import sfb_pkg::*;
#(
   parameter int addr_w = sfb_addr_w_512m,
   parameter int mem_words = 256
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [addr_w-1:0] addr,
   input wire logic [sfb_data_w-1:0] dq_in,
   output logic [sfb_data_w-1:0] dq_out,
   output logic dq_oe,
   input wire logic addr_valid_n,
   input wire logic die_sel_first_n,
   input wire logic die_sel_second_n,
   input wire logic out_en_first_n,
   input wire logic out_en_second_n,
   input wire logic bus_clk,
   input wire logic write_en_n,
   input wire logic write_protect_n,
   input wire logic program_supply_lockout,
   input wire logic core_supply_lockout,
   output logic wait_out,
   output logic wait_oe,
   output logic [addr_w-1:0] latched_addr,
   output logic [sfb_cfg_w-1:0] read_config_reg,
   output logic array_write_blocked
);
   localparam int mem_aw = $clog2(mem_words);
   localparam int n_in = addr_w + sfb_data_w + 10;

   initial begin
      // density sets the address width
      if (addr_w < sfb_addr_w_64m || addr_w > sfb_addr_w_512m)
         $error("addr_w must be 22 to 25");
      if (mem_words < 2 || mem_words > (1 << addr_w))
         $error("mem_words out of range");
   end

   // every pin input passes the three-stage synchroniser
   logic [n_in-1:0] raw_in;
   logic [n_in-1:0] syn_in;
   assign raw_in = {addr, dq_in, addr_valid_n, die_sel_first_n,
      die_sel_second_n, out_en_first_n, out_en_second_n, bus_clk,
      write_en_n, write_protect_n, program_supply_lockout,
      core_supply_lockout};

   sfb_sync3 #(
      .width(n_in),
      .init({{(addr_w + sfb_data_w){1'b0}}, 10'h3eb})
   ) u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(raw_in),
      .q(syn_in)
   );

   logic [addr_w-1:0] s_addr;
   logic [sfb_data_w-1:0] s_dq;
   logic s_adv_n, s_ce1_n, s_ce2_n, s_oe1_n, s_oe2_n, s_clk;
   logic s_we_n, s_wp_n, s_vpp_lk, s_vcc_lk;
   assign {s_addr, s_dq, s_adv_n, s_ce1_n, s_ce2_n, s_oe1_n, s_oe2_n,
      s_clk, s_we_n, s_wp_n, s_vpp_lk, s_vcc_lk} = syn_in;

   typedef struct packed {
      sfb_state_t state;
      logic [addr_w-1:0] addr_hold;
      logic [sfb_cfg_w-1:0] cfg;
      logic adv_n_d;
      logic clk_d;
      logic we_n_d;
      logic sync_latched;
      logic [sfb_lat_w-1:0] lat_cnt;
      logic burst_valid;
      logic prog_err;
      logic locked_any;
      logic lockdown_any;
      logic [sfb_data_w-1:0] dq_out;
      logic dq_oe;
      logic wait_out;
      logic wait_oe;
      logic blocked;
   } sfb_core_t;
   sfb_core_t r;
   sfb_core_t next_r;

   // reset image: async read-array, writes blocked until lockouts clear
   localparam sfb_core_t core_reset = '{
      state: sfb_st_array,
      addr_hold: '0,
      cfg: sfb_cfg_reset,
      adv_n_d: 1'b1,
      clk_d: 1'b0,
      we_n_d: 1'b1,
      sync_latched: 1'b0,
      lat_cnt: sfb_latency_reset,
      burst_valid: 1'b0,
      prog_err: 1'b0,
      locked_any: 1'b0,
      lockdown_any: 1'b0,
      dq_out: '0,
      dq_oe: 1'b0,
      wait_out: 1'b0,
      wait_oe: 1'b0,
      blocked: 1'b1
   };

   // status word: ready, program error and lockout flags
   function automatic logic [sfb_data_w-1:0] status_word(
      input logic err,
      input logic lockout
   );
      return {8'h00, 1'b1, 1'b0, 1'b0, err, lockout, 3'b000};
   endfunction : status_word

   // command byte to next bus state; lock commands leave state alone
   function automatic sfb_state_t cmd_state(
      input sfb_state_t cur,
      input logic [7:0] code
   );
      sfb_state_t nxt;
      nxt = cur;
      case (code)
         sfb_cmd_read_array: nxt = sfb_st_array;
         sfb_cmd_read_status: nxt = sfb_st_status;
         sfb_cmd_cfg_setup: nxt = sfb_st_cfg;
         sfb_cmd_program: nxt = sfb_st_prog;
         default: nxt = cur;
      endcase
      return nxt;
   endfunction : cmd_state

   // array storage, small window of the full address space
   logic [sfb_data_w-1:0] mem [mem_words];
   logic mem_we;
   logic [mem_aw-1:0] mem_wa;
   logic [sfb_data_w-1:0] mem_wd;

   // die and output enable: host ties both oe together, we accept either
   function automatic logic any_low(input logic a, input logic b);
      return !(a && b);
   endfunction : any_low

   logic sel, oe_on, adv_rise, clk_rise, we_rise, sync_mode;
   logic [addr_w-1:0] eff_addr;
   logic wait_assert_lvl;

   always_comb begin
      sel = any_low(s_ce1_n, s_ce2_n);
      oe_on = any_low(s_oe1_n, s_oe2_n);
      adv_rise = s_adv_n && !r.adv_n_d;
      clk_rise = s_clk && !r.clk_d;
      we_rise = s_we_n && !r.we_n_d;
      sync_mode = !r.cfg[sfb_sync_mode_bit];
      wait_assert_lvl = r.cfg[sfb_wait_pol_bit];
      // async mode flows the pins through while valid is low
      if (!s_adv_n && !sync_mode) eff_addr = s_addr;
      else eff_addr = r.addr_hold;
   end

   // main sequencing: latching, commands, burst wait and output drive
   always_comb begin
      next_r = r;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      next_r.adv_n_d = s_adv_n;
      next_r.clk_d = s_clk;
      next_r.we_n_d = s_we_n;
      next_r.blocked = s_vpp_lk || s_vcc_lk;
      if (sel) begin
         // hold the address until the next latch event
         if (sync_mode) begin
            // first of valid rise or clock edge with valid low
            if (adv_rise && !r.sync_latched) begin
               next_r.addr_hold = s_addr;
            end else if (clk_rise && !s_adv_n && !r.sync_latched) begin
               next_r.addr_hold = s_addr;
               next_r.sync_latched = 1'b1;
               next_r.lat_cnt = r.cfg[sfb_lat_lsb +: sfb_lat_w];
               next_r.burst_valid = 1'b0;
            end
            if (s_adv_n) next_r.sync_latched = 1'b0;
            // count clock edges until burst data is valid
            if (clk_rise && r.sync_latched && !r.burst_valid) begin
               if (r.lat_cnt == '0) next_r.burst_valid = 1'b1;
               else next_r.lat_cnt = r.lat_cnt - 1'b1;
            end
         end else if (adv_rise || !s_adv_n) begin
            // low valid lets the address flow, its rise freezes it
            next_r.addr_hold = s_addr;
         end
         // write strobe rise takes address and data
         if (we_rise) begin
            if (!s_adv_n && !sync_mode) next_r.addr_hold = s_addr;
            case (r.state)
               sfb_st_cfg: begin
                  if (s_dq[7:0] == sfb_cmd_cfg_confirm)
                     next_r.cfg = s_addr[sfb_cfg_w-1:0];
                  next_r.state = sfb_st_array;
               end
               sfb_st_prog: begin
                  // lockouts refuse any change to the array
                  if (s_vpp_lk || s_vcc_lk) begin
                     next_r.prog_err = 1'b1;
                  end else if (r.locked_any) begin
                     next_r.prog_err = 1'b1;
                  end else begin
                     mem_we = 1'b1;
                     mem_wa = s_addr[mem_aw-1:0];
                     mem_wd = s_dq;
                  end
                  next_r.state = sfb_st_status;
               end
               default: begin
                  next_r.state = cmd_state(r.state, s_dq[7:0]);
                  case (s_dq[7:0])
                     sfb_cmd_lockdown: begin
                        next_r.locked_any = 1'b1;
                        next_r.lockdown_any = 1'b1;
                     end
                     sfb_cmd_unlock: begin
                        // lock-down holds unless protect pin high
                        if (!r.lockdown_any || s_wp_n)
                           next_r.locked_any = 1'b0;
                     end
                     default: begin
                        next_r.locked_any = r.locked_any;
                     end
                  endcase
               end
            endcase
         end
      end else begin
         next_r.sync_latched = 1'b0;
         next_r.burst_valid = 1'b0;
      end
      // drivers only when selected and output enabled
      next_r.dq_oe = sel && oe_on && s_we_n;
      next_r.wait_oe = sel && oe_on;
      // read data by state
      case (r.state)
         sfb_st_status: next_r.dq_out = status_word(r.prog_err, r.blocked);
         sfb_st_cfg: next_r.dq_out = r.cfg;
         default: next_r.dq_out = mem[eff_addr[mem_aw-1:0]];
      endcase
      // wait only in latched sync reads in any state, idle in async and writes
      if (sync_mode && r.sync_latched && s_we_n && !r.burst_valid)
         next_r.wait_out = wait_assert_lvl;
      else
         next_r.wait_out = !wait_assert_lvl;
   end

   // memory write port; reset blocks it through the nrst term beside mem_we
   always_ff @(posedge sys_clk) begin
      if (nrst && mem_we) mem[mem_wa] <= mem_wd;
   end

   // state register; reset returns to async read-array
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         r <= core_reset;
      end else begin
         r <= next_r;
      end
   end

   assign dq_out = r.dq_out;
   assign dq_oe = r.dq_oe;
   assign wait_out = r.wait_out;
   assign wait_oe = r.wait_oe;
   assign latched_addr = r.addr_hold;
   assign read_config_reg = r.cfg;
   assign array_write_blocked = r.blocked;
endmodule : sfb_flash_bus
`default_nettype wire

//--- sfb_flash_bus_assertions.sv
// pin-level checker for the flash bus front end
`default_nettype none
module sfb_flash_bus_assertions
   import sfb_pkg::*;
#(
   parameter int addr_w = 25
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [addr_w-1:0] addr,
   input wire logic addr_valid_n,
   input wire logic die_sel_first_n,
   input wire logic die_sel_second_n,
   input wire logic out_en_first_n,
   input wire logic out_en_second_n,
   input wire logic write_en_n,
   input wire logic program_supply_lockout,
   input wire logic core_supply_lockout,
   input wire logic dq_oe,
   input wire logic wait_out,
   input wire logic wait_oe,
   input wire logic [addr_w-1:0] latched_addr,
   input wire logic [sfb_cfg_w-1:0] read_config_reg,
   input wire logic array_write_blocked
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // pins pass a synchroniser, so eight samples cover the lag
   ce_data_off_a: assert property ((die_sel_first_n && die_sel_second_n)[*8]
      |-> !dq_oe) else $error("data driven while deselected");
   oe_data_off_a: assert property ((out_en_first_n && out_en_second_n)[*8]
      |-> !dq_oe) else $error("data driven with output enable high");
   ce_wait_off_a: assert property ((die_sel_first_n && die_sel_second_n)[*8]
      |-> !wait_oe) else $error("wait driven while deselected");
   oe_wait_off_a: assert property ((out_en_first_n && out_en_second_n)[*8]
      |-> !wait_oe) else $error("wait driven with output enable high");
   reset_exit_a: assert property ($rose(nrst) |-> !dq_oe && !wait_oe
      && read_config_reg == sfb_cfg_reset) else $error("bad state after reset");
   vpp_lock_a: assert property (program_supply_lockout[*8]
      |-> array_write_blocked) else $error("writes open under program lockout");
   vcc_lock_a: assert property (core_supply_lockout[*8]
      |-> array_write_blocked) else $error("writes open under core lockout");
   async_wait_a: assert property (wait_oe && read_config_reg[sfb_sync_mode_bit]
      |-> wait_out == !read_config_reg[sfb_wait_pol_bit])
      else $error("wait asserted in async mode");
   addr_flow_a: assert property ((!addr_valid_n && $stable(addr)
      && read_config_reg[sfb_sync_mode_bit])[*8] |-> latched_addr == addr)
      else $error("address not flowing through");
   addr_hold_a: assert property ((addr_valid_n && write_en_n
      && read_config_reg[sfb_sync_mode_bit])[*8] |-> $stable(latched_addr))
      else $error("held address changed");
endmodule : sfb_flash_bus_assertions
bind sfb_flash_bus sfb_flash_bus_assertions #(.addr_w(addr_w)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .addr_valid_n(addr_valid_n),
   .die_sel_first_n(die_sel_first_n), .die_sel_second_n(die_sel_second_n),
   .out_en_first_n(out_en_first_n), .out_en_second_n(out_en_second_n),
   .write_en_n(write_en_n), .program_supply_lockout(program_supply_lockout),
   .core_supply_lockout(core_supply_lockout), .dq_oe(dq_oe),
   .wait_out(wait_out), .wait_oe(wait_oe), .latched_addr(latched_addr),
   .read_config_reg(read_config_reg),
   .array_write_blocked(array_write_blocked));
`default_nettype wire

//--- sfb_host_model.sv
// host memory controller model driving the flash pins
`default_nettype none
module sfb_host_model (
   input wire logic sys_clk,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   output logic [24:0] addr,
   output logic [15:0] dq_in,
   output logic addr_valid_n,
   output logic die_sel_first_n,
   output logic die_sel_second_n,
   output logic out_en_first_n,
   output logic out_en_second_n,
   output logic write_en_n,
   output logic rd_valid,
   output logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic die = 1'b0;
   // idle bus: enables high, both output enables moved together
   initial begin
      {die_sel_first_n, die_sel_second_n} = 2'b11;
      {out_en_first_n, out_en_second_n} = 2'b11;
      {addr_valid_n, write_en_n, rd_valid} = 3'b110;
      addr = '0;
      dq_in = '0;
      rd_data = '0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : hold
   // alternate dies so both chip enables see traffic
   task automatic sel(input logic on);
      if (on) die = ~die;
      die_sel_first_n = !(on && !die);
      die_sel_second_n = !(on && die);
   endtask : sel
   // released lines show inverted values, never the last ones
   task automatic wr(input logic [24:0] a, input logic [15:0] d);
      sel(1'b1);
      addr = a;
      dq_in = d;
      addr_valid_n = 1'b0;
      write_en_n = 1'b0;
      hold(6);
      write_en_n = 1'b1;
      hold(6);
      sel(1'b0);
      addr_valid_n = 1'b1;
      addr = ~a;
      dq_in = ~d;
      hold(6);
   endtask : wr
   // address is latched, then scrambled before the data is read
   task automatic rd(input logic [24:0] a);
      int n;
      sel(1'b1);
      addr = a;
      addr_valid_n = 1'b0;
      hold(6);
      addr_valid_n = 1'b1;
      hold(6);
      addr = ~a;
      {out_en_first_n, out_en_second_n} = 2'b00;
      n = 0;
      while (dq_oe !== 1'b1 && n < 20) begin
         hold(1);
         n++;
      end
      hold(2);
      rd_data = dq_out;
      rd_valid = 1'b1;
      hold(1);
      rd_valid = 1'b0;
      {out_en_first_n, out_en_second_n} = 2'b11;
      sel(1'b0);
      hold(6);
   endtask : rd
endmodule : sfb_host_model
`default_nettype wire

//--- test_sfb_flash_bus.sv
// self-checking bench for the flash bus front end
`default_nettype none
module test_sfb_flash_bus
   import sfb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic write_protect_n = 1'b1;
   logic program_supply_lockout = 1'b0;
   logic core_supply_lockout = 1'b0;
   logic bus_clk = 1'b0;
   logic [15:0] cfg_q;
   logic [24:0] addr;
   logic [15:0] dq_in, dq_out, rd_data;
   logic dq_oe, addr_valid_n, die_sel_first_n, die_sel_second_n, rd_valid;
   logic out_en_first_n, out_en_second_n, write_en_n, wait_out, wait_oe;
   logic [15:0] exp_q[$];
   logic [31:0] lfsr = 32'h0001342a;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   always #5 sys_clk = ~sys_clk;
   // slow bus clock, five system cycles per level so the pins settle
   always begin
      repeat (5) @(negedge sys_clk);
      bus_clk = ~bus_clk;
   end
   sfb_flash_bus #(.addr_w(sfb_addr_w_512m)) u_dut (
      .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .addr_valid_n(addr_valid_n),
      .die_sel_first_n(die_sel_first_n), .die_sel_second_n(die_sel_second_n),
      .out_en_first_n(out_en_first_n), .out_en_second_n(out_en_second_n),
      .bus_clk(bus_clk), .write_en_n(write_en_n),
      .write_protect_n(write_protect_n),
      .program_supply_lockout(program_supply_lockout),
      .core_supply_lockout(core_supply_lockout), .wait_out(wait_out),
      .wait_oe(wait_oe), .latched_addr(), .read_config_reg(cfg_q),
      .array_write_blocked());
   sfb_host_model u_host (
      .sys_clk(sys_clk), .dq_out(dq_out), .dq_oe(dq_oe), .addr(addr),
      .dq_in(dq_in), .addr_valid_n(addr_valid_n),
      .die_sel_first_n(die_sel_first_n), .die_sel_second_n(die_sel_second_n),
      .out_en_first_n(out_en_first_n), .out_en_second_n(out_en_second_n),
      .write_en_n(write_en_n), .rd_valid(rd_valid), .rd_data(rd_data));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic compare(input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : compare
   task automatic final_report;
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic cmd(input logic [7:0] c);
      u_host.wr('0, {8'h00, c});
   endtask : cmd
   task automatic prog(input logic [7:0] a, input logic [15:0] d);
      cmd(sfb_cmd_program);
      u_host.wr({17'h00000, a}, d);
   endtask : prog
   task automatic check(input logic [7:0] a, input logic [15:0] d);
      cmd(sfb_cmd_read_array);
      exp_q.push_back(d);
      u_host.rd({17'h00000, a});
   endtask : check
   // monitor: each read result is matched with the oldest note
   always @(posedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         compare(exp_q.pop_front(), rd_data);
      end
   end
   // hang guard, far above the several hundred cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      logic [15:0] d0;
      logic [15:0] d1;
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (6) @(negedge sys_clk);
      lfsr = lfsr_next(lfsr);
      d0 = lfsr[15:0];
      lfsr = lfsr_next(lfsr);
      d1 = lfsr[31:16];
      prog(8'h00, d0);
      prog(8'hff, d1);
      check(8'hff, d1);
      check(8'h00, d0);
      // each lockout alone must refuse a program
      for (int k = 0; k < 2; k++) begin
         {core_supply_lockout, program_supply_lockout} = 2'b01 << k;
         repeat (6) @(negedge sys_clk);
         prog(8'h00, ~d0);
         {core_supply_lockout, program_supply_lockout} = 2'b00;
         check(8'h00, d0);
      end
      write_protect_n = 1'b0;
      cmd(sfb_cmd_lockdown);
      cmd(sfb_cmd_unlock);
      prog(8'h00, ~d0);
      check(8'h00, d0);
      write_protect_n = 1'b1;
      cmd(sfb_cmd_unlock);
      prog(8'h00, ~d0);
      check(8'h00, ~d0);
      // sync mode, one clock of latency, wait asserted low
      cmd(sfb_cmd_cfg_setup);
      u_host.wr(25'h0000bcf, {8'h00, sfb_cmd_cfg_confirm});
      compare(16'h0bcf, cfg_q);
      check(8'hff, d1);
      // second reset: array reads follow without any command
      nrst = 1'b0;
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (6) @(negedge sys_clk);
      compare(sfb_cfg_reset, cfg_q);
      exp_q.push_back(d1);
      u_host.rd(25'h00000ff);
      final_report();
   end
endmodule : test_sfb_flash_bus
`default_nettype wire
